// ==== include/adc_port_pkg.sv ====
// constants and types shared by the converter serial port control
package adc_port_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int RES_BITS = 12;       // result width
	localparam int CFG_BITS = 3;        // configuration word width
	localparam int CNT_W    = 4;        // edge counter width

	// ----------------------------------------------------------------
	// configuration word layout, shifted in flag first
	// ----------------------------------------------------------------
	localparam int CFG_SGL   = 2;       // single_ended_flag
	localparam int CFG_POL   = 1;       // polarity bit
	localparam int CFG_ORDER = 0;       // output_order_bit

	// config bit count at which tracking starts (bit before order bit)
	localparam logic [CNT_W-1:0] CFG_TRACK_CNT = 4'h1;
	// config bit count of the last config bit
	localparam logic [CNT_W-1:0] CFG_LAST_CNT  = 4'h2;

	// ----------------------------------------------------------------
	// single-channel variant: falling edge that enables the driver
	// ----------------------------------------------------------------
	localparam logic [CNT_W-1:0] SC_ENABLE_FALL = 4'h2;

	// first bit index of the lsb-first repeat
	localparam logic [CNT_W-1:0] LSB_FIRST_IDX = 4'h1;

	// ----------------------------------------------------------------
	// negative input selection codes
	// ----------------------------------------------------------------
	localparam logic [1:0] NEG_GND = 2'h0;
	localparam logic [1:0] NEG_CH0 = 2'h1;
	localparam logic [1:0] NEG_CH1 = 2'h2;

	// reset values
	localparam logic [CFG_BITS-1:0] CFG_RESET = 3'h0;
	localparam logic [CNT_W-1:0]    CNT_RESET = 4'h0;

	// ----------------------------------------------------------------
	// exchange phases
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		PH_HUNT,
		PH_CONFIG,
		PH_TRACK,
		PH_CONVERT,
		PH_LSB,
		PH_ZERO
	} phase_type;

endpackage

// ==== hw/serial_adc_port_control.sv ====
// serial port and conversion sequencing of a 12-bit sampling converter
// Operation
// - launch on clock fall, sample on rise
// - single-channel variant starts on select fall alone
// - single-channel driver enabled on second clock
// - one low null bit precedes result
// - select high returns serial logic to idle
// - select low enables, high powers down
// - two-channel receives word first, then transmits
// - leading zeros ignored, first one starts
// - three-bit word sets mux, order, starts conversion
// - further input ignored until next select cycle
// - flag and polarity decode the input pair
// - order bit one: msb first then zeros
// - order bit zero: msb first then lsb first
// - single-channel always msb then lsb first
// - zeros driven after transfer while select low
// - straight binary unipolar twelve-bit result
// - input tracked about one and half cycles
// - tracking from bit before order bit
// - driver takes line fourth fall after start
// - core powers down after each conversion
`timescale 1ns/1ns
`default_nettype none

module serial_adc_port_control #(
	parameter bit TWO_CHANNEL = 1'b1,
	parameter int RES         = adc_port_pkg::RES_BITS
) (
	// clock and reset
	input  wire logic           clk,
	input  wire logic           rstn,
	// serial pins from the host
	input  wire logic           selectAndPowerDownN,
	input  wire logic           shiftClk,
	input  wire logic           serIn,
	// serial output pin
	output logic                serOut,
	output logic                serOutEn,
	// analog core control
	input  wire logic           compIn,
	output logic [RES-1:0]      dacCode,
	output logic                coreOn,
	output logic                trackEn,
	// input multiplexer selection
	output logic                plusIsOne,
	output logic [1:0]          minusSel,
	// state for observation
	output logic [RES-1:0]      lastResult,
	output logic                resultValid
);

	// ----------------------------------------------------------------
	// local sizes
	// ----------------------------------------------------------------
	localparam int CW = adc_port_pkg::CNT_W;
	localparam int FW = adc_port_pkg::CFG_BITS;
	localparam logic [CW-1:0] LAST_BIT = CW'(RES - 1);
	localparam logic [RES-1:0] MSB_ONE = {1'b1, {(RES-1){1'b0}}};

	// ----------------------------------------------------------------
	// state of the whole block
	// ----------------------------------------------------------------
	typedef struct packed {
		logic                   selMeta;
		logic                   selSync;
		logic                   clkMeta;
		logic                   clkSync;
		logic                   clkPrev;
		logic                   dinMeta;
		logic                   dinSync;
		adc_port_pkg::phase_type phase;
		logic [CW-1:0]          cnt;
		logic [FW-1:0]          cfg;
		logic [RES-1:0]         code;
		logic [RES-1:0]         mask;
		logic                   outBit;
		logic                   outEn;
		logic                   track;
		logic                   core;
		logic                   done;
	} state_type;

	state_type stateFf;
	state_type nxtState;

	logic clkRise;
	logic clkFall;
	logic msbOnly;

	// ----------------------------------------------------------------
	// multiplexer decode from flag and polarity
	// ----------------------------------------------------------------
	function automatic logic [2:0] muxDecode(input logic sgl, input logic pol);
		logic [2:0] sel;
		sel = {pol, adc_port_pkg::NEG_GND};
		if (!sgl) begin
			sel = pol ? {1'b1, adc_port_pkg::NEG_CH0}
			          : {1'b0, adc_port_pkg::NEG_CH1};
		end
		return sel;
	endfunction

	// ----------------------------------------------------------------
	// edge detection on the synchronised shift clock
	// ----------------------------------------------------------------
	assign clkRise = stateFf.clkSync & ~stateFf.clkPrev;
	assign clkFall = ~stateFf.clkSync & stateFf.clkPrev;

	// single-channel variant never stops after the msb-first result
	assign msbOnly = TWO_CHANNEL & stateFf.cfg[adc_port_pkg::CFG_ORDER];

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		nxtState = stateFf;

		// two-flop synchronisers for the host pins
		nxtState.selMeta = selectAndPowerDownN;
		nxtState.selSync = stateFf.selMeta;
		nxtState.clkMeta = shiftClk;
		nxtState.clkSync = stateFf.clkMeta;
		nxtState.clkPrev = stateFf.clkSync;
		nxtState.dinMeta = serIn;
		nxtState.dinSync = stateFf.dinMeta;

		if (stateFf.selSync) begin
			// select high: idle, powered down, driver off
			nxtState.phase  = adc_port_pkg::PH_HUNT;
			nxtState.cnt    = adc_port_pkg::CNT_RESET;
			nxtState.cfg    = adc_port_pkg::CFG_RESET;
			nxtState.outBit = 1'b0;
			nxtState.outEn  = 1'b0;
			nxtState.track  = 1'b0;
			nxtState.core   = 1'b0;
		end else begin
			unique case (stateFf.phase)
				adc_port_pkg::PH_HUNT: begin
					// select low wakes the core
					nxtState.core = 1'b1;
					if (TWO_CHANNEL) begin
						// zeros skipped, first one is the start bit
						if (clkRise && stateFf.dinSync) begin
							nxtState.phase = adc_port_pkg::PH_CONFIG;
							nxtState.cnt   = adc_port_pkg::CNT_RESET;
						end
					end else begin
						// no word: track from select fall
						nxtState.track = 1'b1;
						if (clkFall) begin
							nxtState.cnt = stateFf.cnt + 1'b1;
						end
						if (clkFall && (stateFf.cnt + 1'b1 == adc_port_pkg::SC_ENABLE_FALL)) begin
							// second clock: null bit, hold
							nxtState.phase  = adc_port_pkg::PH_CONVERT;
							nxtState.track  = 1'b0;
							nxtState.outEn  = 1'b1;
							nxtState.outBit = 1'b0;
							nxtState.code   = MSB_ONE;
							nxtState.mask   = MSB_ONE;
							nxtState.cnt    = adc_port_pkg::CNT_RESET;
						end
					end
				end

				adc_port_pkg::PH_CONFIG: begin
					// word shifted in flag first on rising edges
					if (clkRise) begin
						nxtState.cfg = {stateFf.cfg[FW-2:0], stateFf.dinSync};
						nxtState.cnt = stateFf.cnt + 1'b1;
						if (stateFf.cnt == adc_port_pkg::CFG_TRACK_CNT) begin
							nxtState.track = 1'b1;
						end
						if (stateFf.cnt == adc_port_pkg::CFG_LAST_CNT) begin
							nxtState.phase = adc_port_pkg::PH_TRACK;
						end
					end
				end

				adc_port_pkg::PH_TRACK: begin
					// fall after order bit: hold, take the line
					if (clkFall) begin
						nxtState.phase  = adc_port_pkg::PH_CONVERT;
						nxtState.track  = 1'b0;
						nxtState.outEn  = 1'b1;
						nxtState.outBit = 1'b0;
						nxtState.code   = MSB_ONE;
						nxtState.mask   = MSB_ONE;
						nxtState.cnt    = adc_port_pkg::CNT_RESET;
					end
				end

				adc_port_pkg::PH_CONVERT: begin
					// one decision per falling edge, sent as found
					if (clkFall) begin
						nxtState.outBit = compIn;
						nxtState.code   = (compIn ? stateFf.code : stateFf.code & ~stateFf.mask)
						                  | (stateFf.mask >> 1);
						nxtState.mask   = stateFf.mask >> 1;
						nxtState.cnt    = stateFf.cnt + 1'b1;
						if (stateFf.cnt == LAST_BIT) begin
							// last bit: core sleeps, port keeps shifting
							nxtState.core  = 1'b0;
							nxtState.done  = 1'b1;
							nxtState.cnt   = adc_port_pkg::LSB_FIRST_IDX;
							nxtState.phase = msbOnly ? adc_port_pkg::PH_ZERO
							                         : adc_port_pkg::PH_LSB;
						end
					end
				end

				adc_port_pkg::PH_LSB: begin
					// repeat of the result, least significant first
					if (clkFall) begin
						nxtState.outBit = stateFf.code[stateFf.cnt];
						nxtState.cnt    = stateFf.cnt + 1'b1;
						if (stateFf.cnt == LAST_BIT) begin
							nxtState.phase = adc_port_pkg::PH_ZERO;
						end
					end
				end

				adc_port_pkg::PH_ZERO: begin
					// transfer over: zeros until select rises
					if (clkFall) begin
						nxtState.outBit = 1'b0;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			stateFf         <= '0;
			// select synchroniser starts at the pin's idle level, no false select
			stateFf.selMeta <= 1'b1;
			stateFf.selSync <= 1'b1;
		end else begin
			stateFf <= nxtState;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign serOut      = stateFf.outBit;
	assign serOutEn    = stateFf.outEn;
	assign dacCode     = stateFf.code;
	assign coreOn      = stateFf.core;
	assign trackEn     = stateFf.track;
	assign lastResult  = stateFf.code;
	assign resultValid = stateFf.done;

	// input pair from the configuration word
	assign {plusIsOne, minusSel} = muxDecode(stateFf.cfg[adc_port_pkg::CFG_SGL],
	                                         stateFf.cfg[adc_port_pkg::CFG_POL]);

endmodule // serial_adc_port_control

`default_nettype wire

// ==== tb/serial_adc_port_checker_assertions.sv ====
// pin-level assertions for the converter serial port control
`timescale 1ns/1ns
`default_nettype none
module serial_adc_port_checker #(
	parameter bit TWO_CHANNEL = 1'b1,
	parameter int RES         = 12
) (
	// clock and reset
	input wire logic           clk,
	input wire logic           rstn,
	// host pins
	input wire logic           selectAndPowerDownN,
	input wire logic           shiftClk,
	input wire logic           serIn,
	// serial output
	input wire logic           serOut,
	input wire logic           serOutEn,
	// analog core
	input wire logic           compIn,
	input wire logic [RES-1:0] dacCode,
	input wire logic           coreOn,
	input wire logic           trackEn,
	// mux and result
	input wire logic           plusIsOne,
	input wire logic [1:0]     minusSel,
	input wire logic [RES-1:0] lastResult,
	input wire logic           resultValid
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// assertions on the pins
	a_idle_hiz: assert property (selectAndPowerDownN [*5] |-> !serOutEn)
		else $error("output driven while deselected");
	a_power_down: assert property (selectAndPowerDownN [*5] |-> !coreOn && !trackEn)
		else $error("core active while deselected");
	a_en_holds: assert property (!selectAndPowerDownN [*4] ##0 serOutEn |=> serOutEn)
		else $error("driver dropped while selected");
	a_en_rise: assert property ($rose(serOutEn) |-> !selectAndPowerDownN
		&& !$past(selectAndPowerDownN, 4))
		else $error("driver enabled without select");
	a_null_bit: assert property ($fell(trackEn) && !selectAndPowerDownN |-> serOutEn
		&& !serOut && dacCode == {1'b1, {(RES-1){1'b0}}})
		else $error("hold start without null bit");
	a_track_len: assert property ($rose(trackEn) |-> trackEn [*8])
		else $error("tracking too short");
	a_core_auto: assert property ($fell(coreOn) && !selectAndPowerDownN
		|-> serOutEn && resultValid)
		else $error("core off outside conversion end");
	a_mux_code: assert property (minusSel == adc_port_pkg::NEG_GND
		|| (minusSel == adc_port_pkg::NEG_CH0) == plusIsOne && minusSel != 2'h3)
		else $error("illegal input pair");
	// main scenarios reached
	c_done: cover property ($rose(resultValid));
	c_hold: cover property ($fell(trackEn));
	c_drive: cover property ($rose(serOutEn));
endmodule // serial_adc_port_checker

bind serial_adc_port_control serial_adc_port_checker #(.TWO_CHANNEL(TWO_CHANNEL), .RES(RES)) chk (
	.clk(clk), .rstn(rstn), .selectAndPowerDownN(selectAndPowerDownN),
	.shiftClk(shiftClk), .serIn(serIn), .serOut(serOut), .serOutEn(serOutEn),
	.compIn(compIn), .dacCode(dacCode), .coreOn(coreOn), .trackEn(trackEn),
	.plusIsOne(plusIsOne), .minusSel(minusSel), .lastResult(lastResult),
	.resultValid(resultValid));
`default_nettype wire

// ==== tb/adc_host_model.sv ====
// host model: drives select, shift clock and serial input
`timescale 1ns/1ns
`default_nettype none
module adc_host_model (
	// clock
	input  wire logic clk,
	// device output
	input  wire logic serOut,
	input  wire logic serOutEn,
	// host pins
	output logic      selN,
	output logic      sck,
	output logic      sdi
);
	// idle pins
	initial begin
		selN = 1'b1;
		sck = 1'b0;
		sdi = 1'b0;
	end
	// one bit: launch on fall, sample on rise
	task automatic bitx(input logic d, output logic q);
		sck = 1'b0;
		sdi = d;
		repeat (5) @(negedge clk);
		q = serOutEn ? serOut : 1'b1; // host pin pulled up while released
		sck = 1'b1;
		repeat (5) @(negedge clk);
	endtask
	// one exchange, select left low at the end
	task automatic xfer(input logic [2:0] c, input int lead, input int n,
		output logic [30:1] got);
		logic q;
		got = '0;
		selN = 1'b0;
		repeat (4) @(negedge clk);
		repeat (lead) bitx(1'b0, q);
		bitx(1'b1, q);
		for (int i = 2; i >= 0; i--) bitx(c[i], q);
		// line let go: input toggles every bit
		for (int k = 1; k <= n; k++) bitx(k[0], got[k]);
	endtask
	// single-channel exchange: select fall alone starts it
	task automatic xferSc(input int n, output logic [30:1] got);
		got = '0;
		selN = 1'b0;
		repeat (4) @(negedge clk);
		for (int k = 1; k <= n; k++) bitx(1'b0, got[k]);
	endtask
	// end of exchange, shift clock parked low
	task automatic finish();
		selN = 1'b1;
		sck = 1'b0;
		repeat (12) @(negedge clk);
	endtask
endmodule // adc_host_model
`default_nettype wire

// ==== tb/serial_adc_port_control_tb_top.sv ====
// self-checking bench for the converter serial port control
`timescale 1ns/1ns
`default_nettype none
module serial_adc_port_control_tb_top;
	logic        clk, rstn, selN, sck, sdi, serOut, serOutEn, compIn;
	logic        coreOn, trackEn, plusIsOne, resultValid;
	logic [1:0]  minusSel;
	logic [11:0] dacCode, lastResult, vin;
	logic [30:1] got;
	logic        selSc, sckSc, sdiSc, serOutSc, serOutEnSc, compInSc;
	logic        coreOnSc, trackEnSc, plusIsOneSc, resultValidSc;
	logic [1:0]  minusSelSc;
	logic [11:0] dacCodeSc, lastResultSc;
	logic [30:1] gotSc;
	int          n_fail, num_checks;
	// comparators of the analog cores
	assign compIn = (vin >= dacCode);
	assign compInSc = (vin >= dacCodeSc);
	serial_adc_port_control #(.TWO_CHANNEL(1'b1), .RES(12)) dut (
		.clk(clk), .rstn(rstn), .selectAndPowerDownN(selN), .shiftClk(sck),
		.serIn(sdi), .serOut(serOut), .serOutEn(serOutEn), .compIn(compIn),
		.dacCode(dacCode), .coreOn(coreOn), .trackEn(trackEn),
		.plusIsOne(plusIsOne), .minusSel(minusSel), .lastResult(lastResult),
		.resultValid(resultValid));
	adc_host_model host (.clk(clk), .serOut(serOut), .serOutEn(serOutEn), .selN(selN),
		.sck(sck), .sdi(sdi));
	// single-channel variant with its own host
	serial_adc_port_control #(.TWO_CHANNEL(1'b0), .RES(12)) dutSc (
		.clk(clk), .rstn(rstn), .selectAndPowerDownN(selSc), .shiftClk(sckSc),
		.serIn(sdiSc), .serOut(serOutSc), .serOutEn(serOutEnSc), .compIn(compInSc),
		.dacCode(dacCodeSc), .coreOn(coreOnSc), .trackEn(trackEnSc),
		.plusIsOne(plusIsOneSc), .minusSel(minusSelSc), .lastResult(lastResultSc),
		.resultValid(resultValidSc));
	adc_host_model hostSc (.clk(clk), .serOut(serOutSc), .serOutEn(serOutEnSc), .selN(selSc),
		.sck(sckSc), .sdi(sdiSc));
	// clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("FAIL t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic conclude();
		$display("checks=%0d fails=%0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// expected output bit k after the word
	function automatic logic expbit(input logic [2:0] c, input logic [11:0] v, input int k);
		if (k >= 2 && k <= 13) return v[13-k];
		if (k >= 14 && k <= 24 && !c[adc_port_pkg::CFG_ORDER]) return v[k-13];
		return 1'b0;
	endfunction
	// main sequence
	initial begin
		logic [2:0] c;
		int n;
		void'($urandom(32'h1783));
		n_fail = 0;
		num_checks = 0;
		rstn = 1'b0;
		vin = 12'h000;
		repeat (10) @(negedge clk);
		rstn = 1'b1;
		chk(serOutEn, 32'h0);
		repeat (4) @(negedge clk);
		for (int i = 0; i < 10; i++) begin
			if (i == 5) begin
				// mid-run reset clears the sticky result flags
				rstn = 1'b0;
				@(negedge clk);
				chk({resultValid, resultValidSc, serOutEn, coreOn}, 32'h0);
				rstn = 1'b1;
				repeat (4) @(negedge clk);
			end
			c = (i < 8) ? i[2:0] : 3'($urandom);
			vin = (i == 0) ? 12'h000 : (i == 7) ? 12'hfff : 12'($urandom);
			n = (i == 3) ? 13 : 30;
			host.xfer(c, $urandom_range(3, 0), n, got);
			for (int k = 1; k <= n; k++) chk(got[k], expbit(c, vin, k));
			chk(lastResult, vin);
			chk(resultValid, 32'h1);
			chk(plusIsOne, c[1]);
			chk(minusSel, c[2] ? adc_port_pkg::NEG_GND : c[1] ? adc_port_pkg::NEG_CH0
				: adc_port_pkg::NEG_CH1);
			chk(coreOn, 32'h0);
			host.finish();
			chk({serOutEn, coreOn, trackEn}, 32'h0);
			// single-channel: released line reads high until the second clock
			hostSc.xferSc((n == 13) ? 15 : 30, gotSc);
			for (int k = 1; k <= ((n == 13) ? 15 : 30); k++)
				chk(gotSc[k], (k < 3) ? 1'b1 : expbit(3'h0, vin, k - 2));
			chk(lastResultSc, vin);
			chk({resultValidSc, coreOnSc}, 32'h2);
			hostSc.finish();
			chk({serOutEnSc, coreOnSc, trackEnSc}, 32'h0);
		end
		conclude();
	end
	// watchdog
	initial begin
		#200000;
		n_fail++;
		conclude();
	end
endmodule // serial_adc_port_control_tb_top
`default_nettype wire
